// ### gpm_pkg.sv
// Behaviour
// - Direction bit 1 makes the pin an input with port driver off.
// - Direction bit 0 drives the pin from its output latch bit.
// - Reset sets every implemented direction bit, so all pins are inputs.
// - Pin value read returns the live pin level, not the latch.
// - Pin value write stores into the output latch, direction untouched.
// - Read-modify-write on pin value copies live levels into the latch.
// - Output latch read returns stored latch values, whatever the pins show.
// - Output latch write updates the latch exactly like a pin value write.
// - Unimplemented bits are disabled; latch, direction, pin read as zero.
// - Peripheral-owned pins stay readable; port driving is disabled.
// - Per-pin muxes give data and enable to enabled owning peripherals first.
// - With several peripherals enabled, the first-listed one takes the pin.
// - Input-only peripherals leave the port driver; latch reaches their input.
// - Interrupt, timer clock, capture, fault inputs accept latch-driven levels.
// - Serial peripherals fully own their pins; latch and direction ignored.
package gpm_pkg;

    localparam int          GPM_PINS       = 16;
    localparam int          GPM_SLOTS      = 2;
    localparam int          GPM_AW         = 8;
    localparam int          GPM_DW         = 32;

    localparam logic [7:0]  GPM_OFF_DIR    = 8'h00;
    localparam logic [7:0]  GPM_OFF_PIN    = 8'h04;
    localparam logic [7:0]  GPM_OFF_LAT    = 8'h08;
    localparam logic [7:0]  GPM_OFF_ANA    = 8'h0C;

    localparam logic [15:0] GPM_IMPL_DEF   = 16'hFFFF;
    localparam logic [15:0] GPM_ACAP_DEF   = 16'h00FF;
    localparam logic [15:0] GPM_LAT_RST    = 16'h0000;
    localparam logic [15:0] GPM_ANA_RST    = 16'h0000;

    localparam logic [1:0]  GPM_RESP_OKAY  = 2'h0;
    localparam logic [1:0]  GPM_RESP_SLV   = 2'h2;

endpackage

// ### gpm_pin_mux.sv
`timescale 1ns/1ns
`default_nettype none
module gpm_pin_mux #(
    parameter int N = gpm_pkg::GPM_PINS,
    parameter int S = gpm_pkg::GPM_SLOTS
) (
    // Port controls
    input  wire logic [N-1:0]   dir,
    input  wire logic [N-1:0]   lat,
    input  wire logic [N-1:0]   impl,
    // Peripherals, slot 0 first in priority
    input  wire logic [S*N-1:0] per_en,
    input  wire logic [S*N-1:0] per_own,
    input  wire logic [S*N-1:0] per_do,
    input  wire logic [S*N-1:0] per_oe,
    // Pad drive
    output logic      [N-1:0]   pad_o,
    output logic      [N-1:0]   pad_e
);
    genvar p;
    generate
        for (p = 0; p < N; p++) begin : g_pin
            always_comb begin
                logic hit;
                hit = 1'b0;
                pad_o[p] = lat[p];
                pad_e[p] = ~dir[p];
                for (int s = 0; s < S; s++) begin
                    if (!hit && per_en[s*N+p]) begin
                        hit = 1'b1;
                        if (per_own[s*N+p]) begin
                            pad_o[p] = per_do[s*N+p];
                            pad_e[p] = per_oe[s*N+p];
                        end
                    end
                end
                if (!impl[p]) begin
                    pad_o[p] = 1'b0;
                    pad_e[p] = 1'b0;
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// ### gpm_port.sv
// The address map and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module gpm_port
    import gpm_pkg::*;
#(
    parameter int          N    = gpm_pkg::GPM_PINS,
    parameter int          S    = gpm_pkg::GPM_SLOTS,
    parameter logic [15:0] IMPL = gpm_pkg::GPM_IMPL_DEF,
    parameter logic [15:0] ACAP = gpm_pkg::GPM_ACAP_DEF
) (
    // Clock and reset
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    // Write address
    input  wire logic [GPM_AW-1:0]     s_axi_awaddr,
    input  wire logic [2:0]            s_axi_awprot,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    // Write data
    input  wire logic [GPM_DW-1:0]     s_axi_wdata,
    input  wire logic [GPM_DW/8-1:0]   s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    // Write response
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    // Read address
    input  wire logic [GPM_AW-1:0]     s_axi_araddr,
    input  wire logic [2:0]            s_axi_arprot,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    // Read data
    output logic [GPM_DW-1:0]          s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    // Pads
    input  wire logic [N-1:0]          pad_i,
    output logic      [N-1:0]          pad_o,
    output logic      [N-1:0]          pad_oe,
    // Peripherals, slot 0 first in priority
    input  wire logic [S*N-1:0]        per_en,
    input  wire logic [S*N-1:0]        per_own,
    input  wire logic [S*N-1:0]        per_do,
    input  wire logic [S*N-1:0]        per_oe,
    output logic      [N-1:0]          per_din
);
    import gpm_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // Storage

    logic [N-1:0]        impl_mask;
    logic [N-1:0]        acap_mask;
    logic [N-1:0]        dir_reg;
    logic [N-1:0]        lat_reg;
    logic [N-1:0]        ana_reg;
    logic [N-1:0]        sync1_reg;
    logic [N-1:0]        sync2_reg;
    logic [N-1:0]        live;
    logic [N-1:0]        mux_o;
    logic [N-1:0]        mux_e;

    logic                aw_full_reg;
    logic                w_full_reg;
    logic [GPM_AW-1:0]   aw_addr_reg;
    logic [GPM_DW-1:0]   w_data_reg;
    logic [GPM_DW/8-1:0] w_strb_reg;
    logic                do_write;
    logic                do_read;

    assign impl_mask = IMPL[N-1:0];
    assign acap_mask = ACAP[N-1:0];

    ////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic [N-1:0] merge(
        input logic [N-1:0]        old,
        input logic [GPM_DW-1:0]   data,
        input logic [GPM_DW/8-1:0] strb
    );
        logic [GPM_DW-1:0] w;
        w = {{(GPM_DW-N){1'b0}}, old};
        for (int b = 0; b < GPM_DW/8; b++) begin
            if (strb[b]) begin
                w[b*8 +: 8] = data[b*8 +: 8];
            end
        end
        return w[N-1:0];
    endfunction

    function automatic logic known(input logic [GPM_AW-1:0] a);
        return (a == GPM_OFF_DIR) || (a == GPM_OFF_PIN) ||
               (a == GPM_OFF_LAT) || (a == GPM_OFF_ANA);
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Pin synchroniser

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= pad_i;
            sync2_reg <= sync1_reg;
        end
    end

    // Digital level, masked for unimplemented and analog-mode pins
    assign live = sync2_reg & impl_mask & (ana_reg | ~acap_mask);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            per_din <= '0;
        end else begin
            per_din <= live;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Write channels

    assign do_write = aw_full_reg && w_full_reg && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_reg   <= 1'b0;
            aw_addr_reg   <= '0;
            s_axi_awready <= 1'b1;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_full_reg   <= 1'b1;
            aw_addr_reg   <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end else if (do_write) begin
            aw_full_reg   <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full_reg   <= 1'b0;
            w_data_reg   <= '0;
            w_strb_reg   <= '0;
            s_axi_wready <= 1'b1;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_full_reg   <= 1'b1;
            w_data_reg   <= s_axi_wdata;
            w_strb_reg   <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end else if (do_write) begin
            w_full_reg   <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_wready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= GPM_RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= known(aw_addr_reg) ? GPM_RESP_OKAY
                                               : GPM_RESP_SLV;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Control registers

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dir_reg <= '1;
        end else if (do_write && aw_addr_reg == GPM_OFF_DIR) begin
            dir_reg <= merge(dir_reg, w_data_reg, w_strb_reg) | ~impl_mask;
        end
    end

    // Pin value and latch writes share one path into the latch
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lat_reg <= GPM_LAT_RST[N-1:0];
        end else if (do_write && (aw_addr_reg == GPM_OFF_PIN ||
                                  aw_addr_reg == GPM_OFF_LAT)) begin
            lat_reg <= merge(lat_reg, w_data_reg, w_strb_reg)
                       & impl_mask;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ana_reg <= GPM_ANA_RST[N-1:0];
        end else if (do_write && aw_addr_reg == GPM_OFF_ANA) begin
            ana_reg <= merge(ana_reg, w_data_reg, w_strb_reg) & acap_mask;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read channel

    assign do_read = s_axi_arvalid && s_axi_arready;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
        end else if (do_read) begin
            s_axi_arready <= 1'b0;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_arready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rresp  <= GPM_RESP_OKAY;
            s_axi_rdata  <= '0;
        end else if (do_read) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= known(s_axi_araddr) ? GPM_RESP_OKAY
                                                : GPM_RESP_SLV;
            s_axi_rdata  <= '0;
            case (s_axi_araddr)
                GPM_OFF_DIR: begin
                    s_axi_rdata[N-1:0] <= dir_reg & impl_mask;
                end
                GPM_OFF_PIN: begin
                    s_axi_rdata[N-1:0] <= live;
                end
                GPM_OFF_LAT: begin
                    s_axi_rdata[N-1:0] <= lat_reg;
                end
                GPM_OFF_ANA: begin
                    s_axi_rdata[N-1:0] <= ana_reg;
                end
                default: begin
                    s_axi_rdata <= '0;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
    // A bitwise update written back through the pin value offset
    // carries the live levels read above into the latch.

    ////////////////////////////////////////////////////////////////////
    // Pad drive

    gpm_pin_mux #(
        .N (N),
        .S (S)
    ) u_mux (
        .dir     (dir_reg),
        .lat     (lat_reg),
        .impl    (impl_mask),
        .per_en  (per_en),
        .per_own (per_own),
        .per_do  (per_do),
        .per_oe  (per_oe),
        .pad_o   (mux_o),
        .pad_e   (mux_e)
    );

    // Input-only slots keep the port drive, so latch reaches them via pad
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pad_o  <= '0;
            pad_oe <= '0;
        end else begin
            pad_o  <= mux_o;
            pad_oe <= mux_e;
        end
    end

endmodule
`default_nettype wire

// ### gpm_port_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module gpm_port_monitor #(
    parameter logic [15:0] IMPL = gpm_pkg::GPM_IMPL_DEF,
    parameter logic [15:0] ACAP = gpm_pkg::GPM_ACAP_DEF
) (
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // Register bus
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // Pads and peripherals
    input wire logic [15:0] pad_i,
    input wire logic [15:0] pad_o,
    input wire logic [15:0] pad_oe,
    input wire logic [31:0] per_en,
    input wire logic [31:0] per_own,
    input wire logic [31:0] per_do,
    input wire logic [31:0] per_oe,
    input wire logic [15:0] per_din
);
    import gpm_pkg::*;
    logic [15:0] own0, own1, owned, sel_oe, sel_do, drv, dig;
    logic        ar_bad;
    logic [1:0]  up_cnt;
    assign own0 = per_en[15:0] & per_own[15:0];
    assign own1 = ~per_en[15:0] & per_en[31:16] & per_own[31:16];
    assign owned = (own0 | own1) & IMPL;
    assign sel_oe = (own0 & per_oe[15:0]) | (own1 & per_oe[31:16]);
    assign sel_do = (own0 & per_do[15:0]) | (own1 & per_do[31:16]);
    assign drv = owned & sel_oe;
    assign dig = IMPL & ~ACAP;
    assign ar_bad = !(s_axi_araddr inside {GPM_OFF_DIR, GPM_OFF_PIN,
                                        GPM_OFF_LAT, GPM_OFF_ANA});
    // Cycles since reset release, saturating
    always_ff @(posedge aclk) begin
        if (!aresetn) up_cnt <= 2'h0;
        else if (up_cnt != 2'h3) up_cnt <= up_cnt + 2'h1;
    end
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    property p_rst;
        $rose(aresetn) |-> pad_oe == 16'h0000 && per_din == 16'h0000;
    endproperty
    property p_unimpl;
        ((pad_oe | pad_o | per_din) & ~IMPL) == 16'h0000;
    endproperty
    property p_own_oe;
        owned != 16'h0000 |=> ((pad_oe ^ $past(sel_oe)) & $past(owned)) == 0;
    endproperty
    property p_own_do;
        drv != 16'h0000 |=> ((pad_o ^ $past(sel_do)) & $past(drv)) == 0;
    endproperty
    property p_sync;
        up_cnt == 2'h3 |-> ((per_din ^ $past(pad_i, 3)) & dig) == 16'h0000;
    endproperty
    property p_rd_lat;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid &&
            s_axi_rresp == ($past(ar_bad) ? GPM_RESP_SLV : GPM_RESP_OKAY);
    endproperty
    property p_rd_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    property p_wr_resp;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
            |-> ##[1:2] s_axi_bvalid;
    endproperty
    property p_rd_hi;
        s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000 && !s_axi_arready;
    endproperty
    a_rst: assert property (p_rst)
        else $error("pads driven after reset");
    a_unimpl: assert property (p_unimpl)
        else $error("unimplemented pin active");
    a_own_oe: assert property (p_own_oe)
        else $error("owned pin enable wrong");
    a_own_do: assert property (p_own_do)
        else $error("owned pin data wrong");
    a_sync: assert property (p_sync)
        else $error("pin level not synchronised");
    a_rd_lat: assert property (p_rd_lat)
        else $error("read answer late or wrong code");
    a_rd_hold: assert property (p_rd_hold)
        else $error("read data not held");
    a_wr_resp: assert property (p_wr_resp)
        else $error("write answer late");
    a_rd_hi: assert property (p_rd_hi)
        else $error("upper read bits or order wrong");
    c_own: cover property (drv != 16'h0000);
    c_wait: cover property (s_axi_rvalid && !s_axi_rready);
    c_bad: cover property (s_axi_arvalid && s_axi_arready && ar_bad);
endmodule
bind gpm_port gpm_port_monitor #(.IMPL(IMPL), .ACAP(ACAP)) u_mon (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .pad_i         (pad_i),
    .pad_o         (pad_o),
    .pad_oe        (pad_oe),
    .per_en        (per_en),
    .per_own       (per_own),
    .per_do        (per_do),
    .per_oe        (per_oe),
    .per_din       (per_din)
);
`default_nettype wire

// ### gpm_pad_model.sv
`timescale 1ns/1ns
`default_nettype none
module gpm_pad_model (
    // Port drive
    input  wire logic [15:0] pad_o,
    input  wire logic [15:0] pad_oe,
    // Outside devices
    input  wire logic [15:0] ext_val,
    input  wire logic [15:0] ext_en,
    // Pin level
    output logic      [15:0] pad_i
);
    import gpm_pkg::*;
    // Port drive wins; a released line goes to its pull-up
    assign pad_i = (pad_oe & pad_o) | (~pad_oe & (~ext_en | ext_val));
endmodule
`default_nettype wire

// ### tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
    import gpm_pkg::*;
    localparam logic [15:0] IMPL = 16'h7FFF;
    logic        aclk = 1'b0, aresetn = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_rready = 1'b0, s_axi_bvalid, s_axi_rvalid;
    logic        s_axi_awready, s_axi_wready, s_axi_arready;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [15:0] pad_i, pad_o, pad_oe, per_din;
    logic [15:0] ext_val = 16'h0000, ext_en = 16'h0000;
    logic [31:0] per_en = 0, per_own = 0, per_do = 0, per_oe = 0;
    int          err_count = 0, check_count = 0, seed = 32'h0000_b42d;
    // Some reads raise rready late, so read data must stand under stall
    logic        rd_lag = 1'b0;
    always #10 aclk = ~aclk;
    gpm_port #(.IMPL(IMPL)) i_dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .pad_i(pad_i), .pad_o(pad_o),
        .pad_oe(pad_oe), .per_en(per_en), .per_own(per_own),
        .per_do(per_do), .per_oe(per_oe), .per_din(per_din));
    gpm_pad_model i_pad (.pad_o(pad_o), .pad_oe(pad_oe),
        .ext_val(ext_val), .ext_en(ext_en), .pad_i(pad_i));
    task automatic close_out;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, x, input string w);
        check_count++;
        if (s !== x) begin
            err_count++;
            $display("FAIL %s exp %h seen %h", w, x, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] st, input logic [1:0] xr);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= st;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        chk({30'h0, s_axi_bresp}, {30'h0, xr}, "bresp");
        s_axi_bready <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] x,
                       input logic [1:0] xr, input string w);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= !rd_lag;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
        end while (!(s_axi_rvalid && s_axi_rready));
        chk(s_axi_rdata, x, w);
        chk({30'h0, s_axi_rresp}, {30'h0, xr}, "rresp");
        s_axi_rready <= 1'b0;
    endtask
    // Expected pad drive as {data, enable}
    function automatic logic [31:0] drive(input logic [15:0] d, l);
        logic [31:0] v;
        int k;
        for (int p = 0; p < 16; p++) begin
            k = per_en[p] ? p : p + 16;
            v[p] = (per_en[k] && per_own[k]) ? per_oe[k] : ~d[p];
            v[p+16] = (per_en[k] && per_own[k]) ? per_do[k] : l[p];
            v[p] = v[p] & IMPL[p];
        end
        return v;
    endfunction
    initial begin
        repeat (5000) @(posedge aclk);
        err_count++;
        close_out();
    end
    initial begin
        logic [31:0] v;
        logic [15:0] d, l, e;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        rdc(GPM_OFF_DIR, 32'(IMPL), GPM_RESP_OKAY, "dir");
        chk(32'(pad_oe), 0, "oe");
        rdc(GPM_OFF_LAT, 0, GPM_RESP_OKAY, "lat");
        rdc(8'h10, 0, GPM_RESP_SLV, "bad");
        wr(8'h11, 32'hFFFF_FFFF, 4'hF, GPM_RESP_SLV);
        wr(GPM_OFF_ANA, 32'h0000_00FF, 4'hF, GPM_RESP_OKAY);
        for (int i = 0; i < 24; i++) begin
            d = 16'($random(seed));
            l = 16'($random(seed));
            rd_lag = i[1];
            ext_val <= 16'($random(seed));
            ext_en <= 16'($random(seed));
            per_en <= (i < 2) ? {32{i == 0}} : $random(seed);
            per_own <= (i == 0) ? 32'hFFFF_0000 : $random(seed);
            per_do <= $random(seed);
            per_oe <= $random(seed);
            wr(GPM_OFF_DIR, 32'(d), 4'hF, GPM_RESP_OKAY);
            wr(i[0] ? GPM_OFF_PIN : GPM_OFF_LAT, 32'(l), 4'hF, 0);
            repeat (6) @(posedge aclk);
            v = drive(d, l);
            chk({pad_o & pad_oe, pad_oe}, {v[31:16] & v[15:0], v[15:0]},
                "pad");
            e = ((v[15:0] & v[31:16]) | (~v[15:0] & (~ext_en | ext_val)));
            e = e & IMPL;
            chk(32'(per_din), 32'(e), "din");
            rdc(GPM_OFF_PIN, 32'(e), GPM_RESP_OKAY, "pin");
            rdc(GPM_OFF_LAT, 32'(l & IMPL), 0, "lat");
            rdc(GPM_OFF_DIR, 32'(d & IMPL), 0, "dir");
        end
        per_en <= 0;
        ext_en <= 16'hFFFF;
        ext_val <= 16'h3C5A;
        wr(GPM_OFF_DIR, 32'h0000_FF00, 4'hF, GPM_RESP_OKAY);
        wr(GPM_OFF_LAT, 32'h0000_00A5, 4'hF, GPM_RESP_OKAY);
        repeat (6) @(posedge aclk);
        rdc(GPM_OFF_PIN, 32'h0000_3CA5, GPM_RESP_OKAY, "rmw");
        wr(GPM_OFF_PIN, 32'h0000_3CA5, 4'hF, GPM_RESP_OKAY);
        rdc(GPM_OFF_LAT, 32'h0000_3CA5, GPM_RESP_OKAY, "rmw");
        wr(GPM_OFF_DIR, 32'h0000_0000, 4'hF, GPM_RESP_OKAY);
        repeat (6) @(posedge aclk);
        chk(32'(pad_o), 32'h0000_3CA5, "rmw pad");
        wr(GPM_OFF_LAT, 32'hFFFF_FFFF, 4'h2, GPM_RESP_OKAY);
        rdc(GPM_OFF_LAT, 32'h0000_7FA5, GPM_RESP_OKAY, "strb");
        close_out();
    end
endmodule
`default_nettype wire
